// *** verilog/rcs_params.svh ***
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// Timebase: the clock period and the timebase tick, both in nanoseconds.
`define CLK_PERIOD_NS 50
`define TICK_NS 1000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)

// Reset intervals in microseconds (one timebase tick each).
`define POR_DELAY_US 10
`define INT_RESET_US 2

// Crystal start-up counter: 1024 oscillator periods on a 10-bit counter.
`define OST_LAST 10'h3FF

// Register byte offsets.
`define REG_CFG 12'h000
`define REG_OSC 12'h004
`define REG_FLAGS 12'h008
`define REG_STAT 12'h00C

// Configuration register fields.
`define CFG_NOSC_LSB 0
`define CFG_SWEN_BIT 3
`define CFG_TWOSPD_BIT 4
`define CFG_FAIL_SAFE_CLOCK_MONITOR_BIT 5
`define CFG_EXTCLK_BIT 6
`define CFG_RESET 7'h00

// Oscillator control register fields.
`define OSC_NOSC_LSB 0
`define OSC_SWREQ_BIT 7
`define OSC_CURRENT_OSC_SELECT_LSB 12

// Reset flag positions and the power-on value of the flags.
`define FL_TRAP 15
`define FL_IOPU 14
`define FL_EXT 7
`define FL_SWR 6
`define FL_WDT 4
`define FL_BOR 1
`define FL_POR 0
`define FLAGS_POR 16'h0003
`define FLAGS_MASK 16'hC0D3

// Oscillator source codes.
`define OSC_FRC 3'h0
`define OSC_FRCPLL 3'h1
`define OSC_PRI 3'h2
`define OSC_PRIPLL 3'h3
`define OSC_SECONDARY_CRYSTAL_OSC 3'h4
`define OSC_LOW_POWER_RC_OSC 3'h5
`define OSC_FDIV 3'h6
`define OSC_DCO 3'h7

// AXI responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** verilog/rcs_pkg.sv ***
package rcs_pkg;

  typedef enum logic [3:0] {
    RS_POR = 4'b0001,
    RS_REG = 4'b0010,
    RS_INT = 4'b0100,
    RS_RUN = 4'b1000
  } rst_state_e;

  typedef enum logic [2:0] {
    CK_WAIT = 3'b001,
    CK_INTERIM = 3'b010,
    CK_RUN = 3'b100
  } ck_state_e;

  // Same-clock reset requests from the core, one-cycle pulses or levels.
  typedef struct packed {
    logic wdt;
    logic software_reset;
    logic illegal_op;
    logic uninit_w;
    logic trap_conflict;
  } rst_src_s;

  typedef struct packed {
    logic [9:0] cnt;
    logic done;
  } ost_s;

  typedef struct packed {
    rst_state_e rs;
    ck_state_e ck;
    logic [4:0] pre;
    logic tick;
    logic [7:0] tcnt;
    logic [7:0] rcnt;
    logic por_s1, por_s2, bor_s1, bor_s2, pin_s1, pin_s2;
    logic pll_s1, pll_s2, valid_s1, valid_s2, xt_s1, xt_s2, xt_s3;
    logic [6:0] cfg;
    logic [2:0] nosc;
    logic [2:0] active;
    logic [2:0] tgt;
    logic [15:0] flags;
    logic ost_restart;
    logic clk_rel;
    logic cpu_run;
    logic mrst;
    logic fail_safe_clock_monitor;
    logic fail_seen;
    logic trap;
    logic awready, wready, aw_have, w_have;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready, rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcs_state_s;

endpackage

// *** verilog/ost_counter.sv ***
`timescale 1ns/1ps
`include "rcs_params.svh"

module ost_counter
  import rcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic osc_edge,
  output logic done
);

  ost_s s_q;
  ost_s s_d;

  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d = '0;
    end else if (osc_edge && !s_q.done) begin
      // The last of the 1024 periods releases the clock; the counter then rests.
      if (s_q.cnt == `OST_LAST) begin
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;

endmodule

// *** verilog/reset_clock_release_sequencer.sv ***
`timescale 1ns/1ps
`include "rcs_params.svh"

// Functional notes
// - With clock switching on, power-on and brown-out resets take the source from the config.
// - With clock switching on, pin, watchdog and software resets keep the current source.
// - With clock switching off, every reset takes the source from the config.
// - Power-on holds reset for power-on, regulator and internal delays; brown-out skips the first unless DIGITAL_CTRL_OSC.
// - Pin, watchdog, software, opcode, W-register and trap resets hold only the internal delay.
// - After power-on or brown-out the clock waits on none, lock, start-up counter or RC start-up.
// - A 10-bit counter counts 1024 crystal periods before the crystal clock is released.
// - Two-speed start-up runs on the fast RC first, then moves to the primary when it is ready.
// - Oscillator, counter and lock sequencing run apart from the reset delays.
// - The core does not run until a clock has been released.
// - The clock monitor starts watching when master reset is released.
// - A monitor failure moves to the fast RC and raises an oscillator-fail trap.
// - Start-up counting and lock run alongside the master reset delay.
// - Power-on clears all reset flags but sets the brown-out and power-on flags.
////////////////////////////////////////////////////////////////////////////////

module reset_clock_release_sequencer
  import rcs_pkg::*;
#(
  parameter int REG_STARTUP_US = 10,
  parameter int FRC_STARTUP_US = 2,
  parameter int LOW_POWER_RC_OSC_STARTUP_US = 4,
  parameter int DCO_STARTUP_US = 2
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_on_event,
  input wire logic brown_out_event,
  input wire logic external_reset_pin_n,
  input wire rst_src_s core_reset_req,
  input wire logic pll_locked,
  input wire logic crystal_clk,
  input wire logic sys_clk_valid,
  output logic master_reset_signal,
  output logic sys_clk_release,
  output logic [2:0] sys_clk_source,
  output logic cpu_run_en,
  output logic fail_safe_clock_monitor_active,
  output logic osc_fail_trap
);

  rcs_state_s s_q;
  rcs_state_s n;
  logic ost_done;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_pll(input logic [2:0] src);
    return (src == `OSC_FRCPLL) || (src == `OSC_PRIPLL);
  endfunction

  function automatic logic is_primary(input logic [2:0] src);
    return (src == `OSC_PRI) || (src == `OSC_PRIPLL);
  endfunction

  function automatic logic needs_ost(input logic [2:0] src, input logic ext_clk);
    return (is_primary(src) && !ext_clk) || (src == `OSC_SECONDARY_CRYSTAL_OSC);
  endfunction

  function automatic logic [7:0] rc_ticks(input logic [2:0] src);
    logic [7:0] t;
    t = 8'h00;
    if (src == `OSC_FRC || src == `OSC_FRCPLL || src == `OSC_FDIV) begin
      t = 8'(FRC_STARTUP_US);
    end else if (src == `OSC_LOW_POWER_RC_OSC) begin
      t = 8'(LOW_POWER_RC_OSC_STARTUP_US);
    end else if (src == `OSC_DCO) begin
      t = 8'(DCO_STARTUP_US);
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic por_lvl, bor_lvl, pin_lvl, core_lvl, any_rst, swen, twospd, ext_clk;
  logic restart, twospd_pri, rc_done, src_ready;
  logic [2:0] sel, new_src, cfg_nosc;
  logic [7:0] rc_goal;
  logic [15:0] hw_set;
  logic [31:0] cfg_mw, flags_mw;

  always_comb begin
    n = s_q;
    n.trap = 1'b0;
    n.ost_restart = 1'b0;
    cfg_mw = merge(32'(s_q.cfg), s_q.wdata, s_q.wstrb);
    flags_mw = merge(32'(s_q.flags), s_q.wdata, s_q.wstrb);
    // Two-flop synchronisers for everything that arrives from outside this clock.
    n.por_s1 = power_on_event;
    n.por_s2 = s_q.por_s1;
    n.bor_s1 = brown_out_event;
    n.bor_s2 = s_q.bor_s1;
    n.pin_s1 = external_reset_pin_n;
    n.pin_s2 = s_q.pin_s1;
    n.pll_s1 = pll_locked;
    n.pll_s2 = s_q.pll_s1;
    n.valid_s1 = sys_clk_valid;
    n.valid_s2 = s_q.valid_s1;
    n.xt_s1 = crystal_clk;
    n.xt_s2 = s_q.xt_s1;
    n.xt_s3 = s_q.xt_s2;

    // The timebase never stops, so an interval rounds up by at most one tick.
    n.tick = (s_q.pre == 5'(`TICK_CYCLES - 1));
    n.pre = n.tick ? 5'h00 : s_q.pre + 5'h01;

    por_lvl = s_q.por_s2;
    bor_lvl = s_q.bor_s2;
    pin_lvl = !s_q.pin_s2;
    core_lvl = |core_reset_req;
    any_rst = por_lvl || bor_lvl || pin_lvl || core_lvl;
    cfg_nosc = s_q.cfg[`CFG_NOSC_LSB +: 3];
    swen = s_q.cfg[`CFG_SWEN_BIT];
    twospd = s_q.cfg[`CFG_TWOSPD_BIT];
    ext_clk = s_q.cfg[`CFG_EXTCLK_BIT];
    sel = (!swen || por_lvl || bor_lvl) ? cfg_nosc : s_q.active;
    restart = 1'b0;
    new_src = s_q.tgt;

    // Master reset stage sequencing; a held reset source keeps restarting its stage.
    if (por_lvl) begin
      n.rs = RS_POR;
      n.tcnt = 8'h00;
    end else if (bor_lvl) begin
      n.rs = (sel == `OSC_DCO) ? RS_POR : RS_REG;
      n.tcnt = 8'h00;
    end else if (pin_lvl || core_lvl) begin
      n.rs = RS_INT;
      n.tcnt = 8'h00;
    end else if (s_q.tick) begin
      unique case (s_q.rs)
        RS_POR: begin
          n.tcnt = (s_q.tcnt == 8'(`POR_DELAY_US)) ? 8'h00 : s_q.tcnt + 8'h01;
          n.rs = (s_q.tcnt == 8'(`POR_DELAY_US)) ? RS_REG : RS_POR;
        end
        RS_REG: begin
          n.tcnt = (s_q.tcnt == 8'(REG_STARTUP_US)) ? 8'h00 : s_q.tcnt + 8'h01;
          n.rs = (s_q.tcnt == 8'(REG_STARTUP_US)) ? RS_INT : RS_REG;
        end
        RS_INT: begin
          n.tcnt = (s_q.tcnt == 8'(`INT_RESET_US)) ? 8'h00 : s_q.tcnt + 8'h01;
          n.rs = (s_q.tcnt == 8'(`INT_RESET_US)) ? RS_RUN : RS_INT;
        end
        RS_RUN: begin
          n.tcnt = 8'h00;
        end
        default: begin
          n.rs = RS_POR;
          n.tcnt = 8'h00;
        end
      endcase
    end
    n.mrst = (n.rs != RS_RUN);

    // Among resets, only power-on, brown-out or a change of source restarts the clock delays.
    if (any_rst && (por_lvl || bor_lvl || sel != s_q.active)) begin
      restart = 1'b1;
      new_src = sel;
    end

    // Reset flags: a hardware set always wins over a software write.
    hw_set = 16'h0000;
    hw_set[`FL_BOR] = bor_lvl;
    hw_set[`FL_EXT] = pin_lvl;
    hw_set[`FL_WDT] = core_reset_req.wdt;
    hw_set[`FL_SWR] = core_reset_req.software_reset;
    hw_set[`FL_IOPU] = core_reset_req.illegal_op || core_reset_req.uninit_w;
    hw_set[`FL_TRAP] = core_reset_req.trap_conflict;

    // Clock monitor starts on the cycle master reset falls.
    if (n.mrst) begin
      n.fail_safe_clock_monitor = 1'b0;
    end else if (s_q.mrst && s_q.cfg[`CFG_FAIL_SAFE_CLOCK_MONITOR_BIT]) begin
      n.fail_safe_clock_monitor = 1'b1;
    end
    if (s_q.fail_safe_clock_monitor && !n.mrst && !s_q.valid_s2 && s_q.active != `OSC_FRC) begin
      n.trap = 1'b1;
      n.fail_seen = 1'b1;
      restart = 1'b1;
      new_src = `OSC_FRC;
    end

    // AXI4-Lite write channels are taken independently, then answered together.
    if (s_q.awready && s_axi_awvalid) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      unique case ({s_q.awaddr[11:2], 2'b00})
        `REG_CFG: begin
          n.cfg = cfg_mw[6:0];
        end
        `REG_OSC: begin
          if (s_q.wstrb[0]) begin
            n.nosc = s_q.wdata[`OSC_NOSC_LSB +: 3];
            // A software switch request restarts the delays for the new source.
            if (s_q.wdata[`OSC_SWREQ_BIT] && swen && !n.trap) begin
              restart = 1'b1;
              new_src = s_q.wdata[`OSC_NOSC_LSB +: 3];
            end
          end
        end
        `REG_FLAGS: begin
          n.flags = flags_mw[15:0] & `FLAGS_MASK;
        end
        `REG_STAT: begin
          n.bresp = `RESP_OKAY;
        end
        default: begin
          n.bresp = `RESP_SLVERR;
        end
      endcase
    end
    n.flags = por_lvl ? `FLAGS_POR : (n.flags | hw_set);
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;

    if (s_q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      n.rdata = 32'h0000_0000;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `REG_CFG: n.rdata = 32'(s_q.cfg);
        `REG_OSC: begin
          n.rdata[`OSC_CURRENT_OSC_SELECT_LSB +: 3] = s_q.active;
          n.rdata[`OSC_NOSC_LSB +: 3] = s_q.nosc;
        end
        `REG_FLAGS: n.rdata = 32'(s_q.flags);
        `REG_STAT: n.rdata = 32'({s_q.cpu_run, s_q.fail_seen, s_q.fail_safe_clock_monitor, s_q.clk_rel,
                                  s_q.ck, s_q.rs});
        default: n.rresp = `RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;

    // Clock delays run beside the reset stages and never wait for them.
    twospd_pri = twospd && is_primary(s_q.tgt);
    rc_goal = twospd_pri ? 8'(FRC_STARTUP_US) : rc_ticks(s_q.tgt);
    rc_done = (s_q.rcnt >= rc_goal);
    // The counter clears one cycle after a restart, so its stale done flag is ignored then.
    src_ready = (!needs_ost(s_q.tgt, ext_clk) || (ost_done && !s_q.ost_restart))
                && (!is_pll(s_q.tgt) || s_q.pll_s2);
    if (restart) begin
      n.tgt = new_src;
      n.ck = CK_WAIT;
      n.rcnt = 8'h00;
      n.ost_restart = 1'b1;
      n.clk_rel = 1'b0;
      n.active = (twospd && is_primary(new_src)) ? `OSC_FRC : new_src;
    end else begin
      if (s_q.tick && !rc_done) begin
        n.rcnt = s_q.rcnt + 8'h01;
      end
      unique case (s_q.ck)
        CK_WAIT: begin
          if (!s_q.mrst && rc_done && src_ready) begin
            n.ck = CK_RUN;
            n.clk_rel = 1'b1;
            n.active = s_q.tgt;
          end else if (!s_q.mrst && twospd_pri && rc_done) begin
            n.ck = CK_INTERIM;
            n.clk_rel = 1'b1;
            n.active = `OSC_FRC;
          end
        end
        CK_INTERIM: begin
          if (src_ready) begin
            n.ck = CK_RUN;
            n.active = s_q.tgt;
          end
        end
        CK_RUN: begin
          n.clk_rel = 1'b1;
        end
        default: begin
          n.ck = CK_WAIT;
          n.clk_rel = 1'b0;
        end
      endcase
    end
    n.cpu_run = !n.mrst && n.clk_rel;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Reset release counts as a power-on: the sequence begins with the full delay.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.rs <= RS_POR;
      s_q.ck <= CK_WAIT;
      s_q.pin_s1 <= 1'b1;
      s_q.pin_s2 <= 1'b1;
      s_q.cfg <= `CFG_RESET;
      s_q.flags <= `FLAGS_POR;
      s_q.mrst <= 1'b1;
      s_q.ost_restart <= 1'b1;
    end else begin
      s_q <= n;
    end
  end

  // The crystal is sampled here, so it must run below half the system clock.
  ost_counter u_ost (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(s_q.ost_restart),
    .osc_edge(s_q.xt_s2 && !s_q.xt_s3),
    .done(ost_done)
  );

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign master_reset_signal = s_q.mrst;
  assign sys_clk_release = s_q.clk_rel;
  assign sys_clk_source = s_q.active;
  assign cpu_run_en = s_q.cpu_run;
  assign fail_safe_clock_monitor_active = s_q.fail_safe_clock_monitor;
  assign osc_fail_trap = s_q.trap;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_por_source_cfg: assert property (
    s_q.por_s2 && s_q.cfg[`CFG_SWEN_BIT] |=> s_q.tgt == $past(s_q.cfg[2:0]))
    else $error("power-on source not taken from config");
  a_pin_source_keep: assert property (
    !s_q.pin_s2 && !s_q.por_s2 && !s_q.bor_s2 && s_q.cfg[`CFG_SWEN_BIT] && !s_q.fail_safe_clock_monitor
    |=> s_q.tgt == $past(s_q.tgt))
    else $error("pin reset changed the clock source");
  a_nosw_source_cfg: assert property (
    (s_q.por_s2 || !s_q.pin_s2 || |core_reset_req) && !s_q.cfg[`CFG_SWEN_BIT] && !s_q.fail_safe_clock_monitor
    |=> s_q.tgt == $past(s_q.cfg[2:0]))
    else $error("switching off but source not from config");
  a_por_stage_len: assert property (
    s_q.rs == RS_POR && n.rs == RS_REG && !s_q.bor_s2 |-> s_q.tick && s_q.tcnt == 8'd10)
    else $error("power-on delay ended at the wrong count");
  a_int_stage_len: assert property (
    s_q.rs == RS_INT && n.rs == RS_RUN |-> s_q.tick && s_q.tcnt == 8'd2)
    else $error("internal reset delay ended at the wrong count");
  a_ext_clk_nodelay: assert property (
    s_q.ck == CK_WAIT && !s_q.mrst && s_q.tgt == `OSC_PRI && s_q.cfg[`CFG_EXTCLK_BIT]
    && !s_q.cfg[`CFG_TWOSPD_BIT] && !n.ost_restart |=> s_q.clk_rel)
    else $error("external clock was delayed");
  a_ost_before_release: assert property (
    $rose(s_q.ck == CK_RUN) && s_q.tgt inside {`OSC_PRI, `OSC_PRIPLL, `OSC_SECONDARY_CRYSTAL_OSC}
    && !s_q.cfg[`CFG_EXTCLK_BIT] |-> ost_done)
    else $error("crystal released before 1024 periods");
  a_two_speed_frc: assert property (
    s_q.ck == CK_INTERIM |-> s_q.active == `OSC_FRC && s_q.clk_rel)
    else $error("two-speed interim not on fast RC");
  a_rc_parallel: assert property (
    s_q.mrst && s_q.tick && s_q.ck == CK_WAIT && !n.ost_restart && s_q.rcnt < 8'd2
    && s_q.tgt inside {`OSC_FRC, `OSC_LOW_POWER_RC_OSC}
    |=> s_q.rcnt == $past(s_q.rcnt) + 8'd1)
    else $error("start-up timing stalled during reset");
  a_run_needs_clock: assert property (
    s_q.cpu_run |-> !s_q.mrst && s_q.clk_rel)
    else $error("core runs without a released clock");
  a_gate_after_reset: assert property (
    $rose(s_q.clk_rel) |-> !$past(s_q.mrst))
    else $error("clock gate opened during master reset");
  a_fail_safe_clock_monitor_start: assert property (
    $fell(s_q.mrst) && $past(s_q.cfg[`CFG_FAIL_SAFE_CLOCK_MONITOR_BIT]) |-> s_q.fail_safe_clock_monitor ##0 !s_q.mrst [*1])
    else $error("clock monitor did not start at release");
  a_fail_safe_clock_monitor_fail_trap: assert property (
    s_q.fail_safe_clock_monitor && !n.mrst && !s_q.valid_s2 && s_q.active != `OSC_FRC
    |=> s_q.trap ##1 !s_q.trap)
    else $error("monitor failure without a one-cycle trap");
  a_por_flags: assert property (
    s_q.por_s2 |=> s_q.flags == `FLAGS_POR)
    else $error("power-on flags wrong");

  c_por_to_run: cover property (s_q.rs == RS_INT ##1 s_q.rs == RS_RUN);
  c_two_speed: cover property (s_q.ck == CK_INTERIM ##[1:1000] s_q.ck == CK_RUN);
  c_fail_trap: cover property (s_q.trap);
  c_cpu_run: cover property ($rose(s_q.cpu_run));

endmodule

// *** testbench/osc_partner.sv ***
`timescale 1ns/1ps
// Stands in for the oscillators and the PLL that sit around the sequencer.
module osc_partner #(
  parameter int LOCK_CYC = 20
)(
  input wire logic aclk,
  input wire logic xtal_run,
  input wire logic lock_en,
  input wire logic valid_en,
  output logic crystal_clk,
  output logic pll_locked,
  output logic sys_clk_valid
);
  logic [1:0] div_q = 2'h0;
  int lock_cnt = 0;
  // The crystal runs at a quarter of aclk, so every edge survives the synchroniser.
  // A stopped crystal stands still low instead of holding a stale level.
  always @(posedge aclk) begin
    div_q <= xtal_run ? div_q + 2'h1 : 2'h0;
    lock_cnt <= lock_en ? lock_cnt + int'(lock_cnt < LOCK_CYC) : 0;
  end
  assign crystal_clk = div_q[1];
  assign pll_locked = lock_cnt >= LOCK_CYC;
  assign sys_clk_valid = valid_en;
endmodule

// *** testbench/reset_clock_release_sequencer_test.sv ***
`timescale 1ns/1ps
`include "rcs_params.svh"
module reset_clock_release_sequencer_test;
  import rcs_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic power_on_event = 0, brown_out_event = 0, external_reset_pin_n = 1;
  rst_src_s core_reset_req = '0;
  logic pll_locked, crystal_clk, sys_clk_valid, xtal_run = 1, lock_en = 0, valid_en = 1;
  logic master_reset_signal, sys_clk_release, cpu_run_en, fail_safe_clock_monitor_active;
  logic osc_fail_trap;
  logic [2:0] sys_clk_source;
  int error_cnt = 0, comparisons = 0, n, m;
  int flag_bit[5] = '{4, 6, 14, 14, 15};

  always #25 aclk = ~aclk;

  reset_clock_release_sequencer #(.REG_STARTUP_US(4)) i_reset_clock_release_sequencer (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_on_event, .brown_out_event, .external_reset_pin_n, .core_reset_req, .pll_locked,
    .crystal_clk, .sys_clk_valid, .master_reset_signal, .sys_clk_release, .sys_clk_source,
    .cpu_run_en, .fail_safe_clock_monitor_active, .osc_fail_trap);

  osc_partner #(.LOCK_CYC(20)) i_osc_partner (.aclk, .xtal_run, .lock_en, .valid_en,
    .crystal_clk, .pll_locked, .sys_clk_valid);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s: got %0h, expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi, input string msg);
    chk(32'(v >= lo && v <= hi), 32'h1, msg);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic hang;
    error_cnt++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up;
  endtask

  // Ready and valid are registered, so the value seen at the falling edge is the one
  // that the next rising edge samples; this keeps the bench out of edge races.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ra, rw, rb;
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      rb = s_axi_bvalid;
      @(posedge aclk);
      if (ra) s_axi_awvalid <= 0;
      if (rw) s_axi_wvalid <= 0;
      if (rb) break;
    end
    s_axi_bready <= 0;
    if (k == 50) hang;
  endtask

  task automatic rd(input logic [11:0] a);
    logic ra, rvl;
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (k = 0; k < 50; k++) begin
      @(negedge aclk);
      ra = s_axi_arready;
      rvl = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ra) s_axi_arvalid <= 0;
      if (rvl) break;
    end
    s_axi_rready <= 0;
    if (k == 50) hang;
  endtask

  function automatic logic cond(input int k);
    case (k)
      0: return master_reset_signal === 1'b0;
      1: return sys_clk_release === 1'b1;
      default: return sys_clk_source === `OSC_PRI;
    endcase
  endfunction

  task automatic wt(input int k, output int c);
    c = 0;
    while (!cond(k)) begin
      @(negedge aclk);
      c++;
      if (c > 9000) hang;
    end
  endtask

  // Source 0 is the pin, 1 brown-out, 2 power-on; each is held for five cycles.
  task automatic hit(input int s);
    @(posedge aclk);
    external_reset_pin_n <= s != 0;
    brown_out_event <= s == 1;
    power_on_event <= s == 2;
    repeat (5) @(posedge aclk);
    chk(master_reset_signal, 32'h1, "reset held");
    external_reset_pin_n <= 1;
    brown_out_event <= 0;
    power_on_event <= 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge aclk) begin
    if (aresetn && cpu_run_en === 1'b1) chk(sys_clk_release & ~master_reset_signal, 32'h1, "core early");
  end

  initial begin
    repeat (100000) @(posedge aclk);
    hang;
  end

  initial begin
    repeat (19) @(posedge aclk);
    chk(master_reset_signal, 32'h1, "reset during aresetn");
    @(posedge aclk);
    aresetn <= 1;
    wt(0, n);
    rng(n, 320, 390, "power-on hold");
    wt(1, n);
    chk(sys_clk_source, `OSC_FRC, "source after power-on");
    rd(`REG_FLAGS);
    chk(rv, {16'h0, `FLAGS_POR}, "flags after power-on");
    rd(12'h010);
    chk(rr, `RESP_SLVERR, "unmapped read");
    $display("test power_on finished");
    wr(`REG_CFG, 32'h0000000A);
    hit(0);
    wt(0, n);
    rng(n, 40, 66, "pin hold");
    chk(sys_clk_source, `OSC_FRC, "pin keeps source");
    hit(1);
    wt(0, n);
    rng(n, 120, 166, "brown-out hold");
    chk(sys_clk_release, 32'h0, "gate waits on crystal");
    wt(1, m);
    rng(n + m, 4070, 4140, "crystal count");
    chk(sys_clk_source, `OSC_PRI, "brown-out takes config");
    $display("test switching finished");
    wr(`REG_CFG, 32'h00000005);
    hit(0);
    wt(0, n);
    chk(sys_clk_source, `OSC_LOW_POWER_RC_OSC, "config without switching");
    wr(`REG_CFG, 32'h0000000B);
    hit(1);
    wt(0, n);
    repeat (4300) @(negedge aclk);
    chk(sys_clk_release, 32'h0, "gate waits on lock");
    lock_en <= 1;
    wt(1, n);
    rng(n, 20, 30, "release after lock");
    $display("test pll finished");
    wr(`REG_CFG, 32'h0000001A);
    hit(1);
    wt(0, n);
    wt(1, n);
    rng(n, 0, 4, "interim release");
    chk(sys_clk_source, `OSC_FRC, "interim source");
    wt(2, n);
    rng(n, 3800, 4140, "move to primary");
    $display("test two_speed finished");
    wr(`REG_CFG, 32'h0000002A);
    valid_en <= 0;
    hit(1);
    wt(0, n);
    chk(fail_safe_clock_monitor_active, 32'h1, "monitor starts");
    m = 0;
    repeat (8) begin
      @(negedge aclk);
      m += int'(osc_fail_trap === 1'b1);
    end
    rng(m, 1, 1, "one trap pulse");
    chk(sys_clk_source, `OSC_FRC, "fallback source");
    valid_en <= 1;
    $display("test monitor finished");
    for (int i = 0; i < 5; i++) begin
      wr(`REG_FLAGS, 32'h0);
      core_reset_req <= rst_src_s'(5'h10 >> i);
      @(posedge aclk);
      core_reset_req <= '0;
      repeat (2) @(posedge aclk);
      wt(0, n);
      rng(n, 33, 62, "core reset hold");
      rd(`REG_FLAGS);
      chk(rv, 32'h1 << flag_bit[i], "core reset flag");
    end
    $display("test core_resets finished");
    wr(`REG_CFG, 32'h00000007);
    hit(1);
    wt(0, n);
    rng(n, 320, 390, "brown-out on DIGITAL_CTRL_OSC hold");
    wr(`REG_CFG, 32'h0000004A);
    hit(1);
    wt(0, n);
    wt(1, n);
    rng(n, 0, 2, "external clock not delayed");
    $display("test dco_and_ext_clock finished");
    hit(2);
    wt(0, n);
    rng(n, 320, 390, "power-on event hold");
    rd(`REG_FLAGS);
    chk(rv, {16'h0, `FLAGS_POR}, "flags after event");
    $display("test power_on_event finished");
    wrap_up;
  end
endmodule
